//--- shared/sps_pkg.sv
// package: constants, tables and state types for the start-up sequencer
package sps_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 20;                  // 50 MHz system clock
  localparam int MS_NS          = 1000000;             // one millisecond
  localparam int MS_CYCLES_DEF  = MS_NS / CLK_NS;      // cycles per ms tick
  localparam logic [15:0] INIT_MS = 16'h0002;          // internal initialisation time, ms
  localparam int SYNC_LOSS_NS   = 5000;                // twice the slowest switching period
  localparam int SYNC_LOSS_CYC  = SYNC_LOSS_NS / CLK_NS;
  localparam logic [4:0] TICK_NUM = 5'h04;             // 8 MHz = 50 MHz * 4 / 25
  localparam logic [4:0] TICK_DEN = 5'h19;
  // ----------------------------------------------------------------
  // voltage and rate limits (mV, kHz)
  // ----------------------------------------------------------------
  localparam logic [11:0] VOUT_MIN  = 12'h258;         // 600 mV
  localparam logic [11:0] VOUT_TOP  = 12'he10;         // 3600 mV
  localparam logic [9:0]  RATE_MIN  = 10'h190;         // 400 kHz
  localparam logic [9:0]  RATE_MAX  = 10'h3e8;         // 1000 kHz
  localparam logic [15:0] BASE_KHZ  = 16'h1f40;        // 8000 kHz reference
  localparam logic [7:0]  PG_LOW_DEF  = 8'h5a;         // 90 percent of target
  localparam logic [7:0]  PG_HIGH_DEF = 8'h6e;         // 110 percent of target
  localparam logic [6:0]  ADDR_BASE = 7'h20;           // arbitrary bus address base
  localparam int VTAB_N = 29;
  localparam int RTAB_N = 10;
  localparam logic [11:0] VOLT_TAB [0:VTAB_N-1] = '{
    12'h258, 12'h28a, 12'h2bc, 12'h2ee, 12'h320, 12'h352, 12'h384, 12'h3b6, 12'h3e8, 12'h41a,
    12'h44c, 12'h47e, 12'h4b0, 12'h4e2, 12'h514, 12'h578, 12'h5dc, 12'h640, 12'h6a4, 12'h708,
    12'h76c, 12'h7d0, 12'h834, 12'h898, 12'h8fc, 12'h9c4, 12'haf0, 12'hbb8, 12'hce4};
  localparam logic [9:0] RATE_TAB [0:RTAB_N-1] = '{
    10'h190, 10'h1a5, 10'h1d7, 10'h215, 10'h23b, 10'h267, 10'h2d7, 10'h320, 10'h379, 10'h3e8};
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;  // bit0 on, bit1 pg invert, bit2 sync source
  localparam logic [7:0] REG_VOUT   = 8'h04;
  localparam logic [7:0] REG_DELAY  = 8'h08;
  localparam logic [7:0] REG_RAMP   = 8'h0c;
  localparam logic [7:0] REG_PGDLY  = 8'h10;
  localparam logic [7:0] REG_PGWIN  = 8'h14;  // [7:0] low pct, [15:8] high pct
  localparam logic [7:0] REG_RATE   = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_VMAX   = 8'h20;
  localparam logic [7:0] REG_VTGT   = 8'h24;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_RAMP, SEQ_ON} sps_seq_t;
  typedef struct packed {
    logic       en1, en2, sy1, sy2, sy3;
    logic [4:0] a1, a2, v1, v2;
    logic [3:0] r1, r2;
    logic [1:0] startCnt;
    logic       strapDone;
    logic [6:0] smbAddr;
    logic [11:0] vStrap;
    logic [9:0] fStrap;
    logic       onCmd, pgInv, syncSrc, pgDlySet;
    logic [11:0] voutCmd;
    logic [15:0] dlyMs, rampMs, pgDlyMs;
    logic [7:0] pgLow, pgHigh;
    logic [9:0] fReq;
    logic       fBus;       // set once software writes a rate, so the strap no longer seeds fReq
    sps_seq_t   seq;
    logic [16:0] msCnt;
    logic [15:0] timer, pgCnt;
    logic [11:0] vTarget, rampStep;
    logic       pgQual, pgOut;
    logic [4:0] nDiv, acc, divCnt;
    logic       swPulse, syncOut, syncOe, clkPresent;
    logic [7:0] lossCnt;
    logic       pready, pslverr;
    logic [31:0] prdata;
  } sps_state_t;
endpackage

//--- logic/sps_top.sv
// start-up sequencer, strap decode, power-good and switching-rate logic
//
// Behaviour
// RULE1: act as a bus target accepting the standard configuration and monitoring commands.
// RULE2: bus address comes from address strap; all else but ceiling is bus configurable.
// RULE3: ceiling is strapped voltage plus 10%; programmed voltage clamps to it.
// RULE4: voltage strap decodes through fixed table, 0.60 V up to 3.30 V.
// RULE5: bus-programmed voltage accepted anywhere from 0.6 V to 3.6 V.
// RULE6: turn-on starts delay timer; ramp begins only when delay expires.
// RULE7: zero delay starts ramp after the roughly 2 ms initialisation.
// RULE8: zero ramp time steps the target straight to its final value.
// RULE9: host should program ramps longer than 500 us.
// RULE10: power-good only while output in window and no fault active.
// RULE11: default window is 10%; limits and polarity reprogrammable.
// RULE12: power-good asserts only after programmable delay once conditions hold.
// RULE13: power-good delay defaults to ramp time, independently programmable.
// RULE14: with an external clock present, lock switching to its rising edges.
// RULE15: without external clock, pin low 400, open 571, high 1000 kHz.
// RULE16: rate strap decodes into ten rates, 400 kHz to 1000 kHz.
// RULE17: rate strap sampled only at start-up until power cycled.
// RULE18: bus-programmed rate accepted between 400 kHz and 1 MHz.
// RULE19: rate quantised to 8 MHz over whole N, nearest to request.
// RULE20: host makes exactly one device clock source on shared line.
// RULE21: readback rate reflects the quantised value.
// RULE22: system should tie turn-on pin low under bus control.
// RULE23: power-good drops at once when out of window or faulted.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
module sps_top import sps_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  addrStrapIdx,
  input  wire logic [4:0]  voltStrapIdx,
  input  wire logic [3:0]  rateStrapIdx,
  input  wire logic        turnOnPin,
  input  wire logic        syncIn,
  output logic             syncOut,
  output logic             syncOe,
  input  wire logic [11:0] vMeas,
  input  wire logic        faultActive,
  output logic             pgOut,
  output logic             swPulse,
  output logic [11:0]      vTarget,
  output logic [6:0]       smbAddr
);
  sps_state_t st_ff, nxt_st;

  // ----------------------------------------------------------------
  // derived values
  // ----------------------------------------------------------------
  logic        msTick, turnOn, extEdge, apbAcc, apbWr, inWin, pgCond;
  logic [15:0] vMaxW, pgDlyEff;
  logic [11:0] vMax, voutEff;
  logic [4:0]  nCalc;
  logic [15:0] fQuant;
  logic [19:0] measScaled, winLo, winHi;

  assign msTick = (st_ff.msCnt == 17'(MS_CYCLES - 1));
  assign turnOn = st_ff.en2 | st_ff.onCmd;
  assign extEdge = st_ff.sy2 & ~st_ff.sy3;           // sy1 feeds only sy2
  assign apbAcc = psel & penable & st_ff.pready;
  assign apbWr  = apbAcc & pwrite;

  // ceiling is ten percent above the strapped level [RULE3]
  assign vMaxW = 16'((32'(st_ff.vStrap) * 32'd11) / 32'd10);
  assign vMax  = (vMaxW > 16'(12'hfff)) ? 12'hfff : vMaxW[11:0];

  // clamp the commanded level to the bus range and then the ceiling [RULE3] [RULE5]
  always_comb begin
    voutEff = st_ff.voutCmd;
    if (voutEff < VOUT_MIN) begin
      voutEff = VOUT_MIN;
    end
    if (voutEff > VOUT_TOP) begin
      voutEff = VOUT_TOP;
    end
    if (voutEff > vMax) begin
      voutEff = vMax;
    end
  end

  // nearest whole divisor: round(8000 / f), f already held in 400..1000 [RULE19]
  assign nCalc  = 5'((32'(BASE_KHZ) * 32'd2 + 32'(st_ff.fReq)) / (32'(st_ff.fReq) * 32'd2));
  // readback shows the rate that the divider really makes [RULE21]
  assign fQuant = 16'(32'(BASE_KHZ) / 32'(st_ff.nDiv));

  // window test in percent of target; fault blocks qualification [RULE10] [RULE11]
  assign measScaled = 20'(32'(vMeas) * 32'd100);
  assign winLo      = 20'(32'(st_ff.vTarget) * 32'(st_ff.pgLow));
  assign winHi      = 20'(32'(st_ff.vTarget) * 32'(st_ff.pgHigh));
  assign inWin      = (measScaled >= winLo) && (measScaled <= winHi);
  assign pgCond     = (st_ff.seq == SEQ_ON) && inWin && !faultActive;
  // delay follows the ramp time until software writes its own value [RULE13]
  assign pgDlyEff   = st_ff.pgDlySet ? st_ff.pgDlyMs : st_ff.rampMs;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // two-stage synchronisers for the turn-on, sync and strap pins
    nxt_st.en1 = turnOnPin;
    nxt_st.en2 = st_ff.en1;
    nxt_st.sy1 = syncIn;
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.sy3 = st_ff.sy2;
    nxt_st.a1  = addrStrapIdx;
    nxt_st.a2  = st_ff.a1;
    nxt_st.v1  = voltStrapIdx;
    nxt_st.v2  = st_ff.v1;
    nxt_st.r1  = rateStrapIdx;
    nxt_st.r2  = st_ff.r1;

    // straps are captured once, after the synchronisers have filled [RULE17]
    if (!st_ff.strapDone) begin
      nxt_st.startCnt = st_ff.startCnt + 2'h1;
      if (st_ff.startCnt == 2'h3) begin
        nxt_st.strapDone = 1'b1;
        nxt_st.smbAddr   = ADDR_BASE + 7'(st_ff.a2);                          // [RULE2]
        nxt_st.vStrap    = VOLT_TAB[(st_ff.v2 > 5'(VTAB_N - 1)) ? 5'(VTAB_N - 1) : st_ff.v2]; // [RULE4]
        nxt_st.fStrap    = RATE_TAB[(st_ff.r2 > 4'(RTAB_N - 1)) ? 4'(RTAB_N - 1) : st_ff.r2]; // [RULE15] [RULE16]
        nxt_st.voutCmd   = VOLT_TAB[(st_ff.v2 > 5'(VTAB_N - 1)) ? 5'(VTAB_N - 1) : st_ff.v2];
        if (!st_ff.fBus) begin
          nxt_st.fReq = RATE_TAB[(st_ff.r2 > 4'(RTAB_N - 1)) ? 4'(RTAB_N - 1) : st_ff.r2];
        end
      end
    end

    // apb slave: ready one cycle into the access phase, unmapped answers an error [RULE1]
    nxt_st.pready  = psel & penable & ~st_ff.pready;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata  = 32'h0;
    if (psel & penable & ~st_ff.pready) begin
      if (paddr == REG_CTRL) begin
        nxt_st.prdata = {29'h0, st_ff.syncSrc, st_ff.pgInv, st_ff.onCmd};
      end else if (paddr == REG_VOUT) begin
        nxt_st.prdata = {20'h0, voutEff};
      end else if (paddr == REG_DELAY) begin
        nxt_st.prdata = {16'h0, st_ff.dlyMs};
      end else if (paddr == REG_RAMP) begin
        nxt_st.prdata = {16'h0, st_ff.rampMs};
      end else if (paddr == REG_PGDLY) begin
        nxt_st.prdata = {16'h0, pgDlyEff};
      end else if (paddr == REG_PGWIN) begin
        nxt_st.prdata = {16'h0, st_ff.pgHigh, st_ff.pgLow};
      end else if (paddr == REG_RATE) begin
        nxt_st.prdata = {16'h0, fQuant};                                       // [RULE21]
      end else if (paddr == REG_STATUS) begin
        nxt_st.prdata = {16'h0, 1'b0, st_ff.smbAddr, 2'h0, st_ff.clkPresent, st_ff.strapDone,
                         st_ff.pgQual, st_ff.pgOut, st_ff.seq};
      end else if (paddr == REG_VMAX) begin
        nxt_st.prdata = {20'h0, vMax};
      end else if (paddr == REG_VTGT) begin
        nxt_st.prdata = {20'h0, st_ff.vTarget};
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end
    if (apbWr) begin
      if (paddr == REG_CTRL) begin
        nxt_st.onCmd   = pwdata[0];
        nxt_st.pgInv   = pwdata[1];                                            // [RULE11]
        nxt_st.syncSrc = pwdata[2];
      end else if (paddr == REG_VOUT) begin
        nxt_st.voutCmd = pwdata[11:0];                                         // [RULE5]
      end else if (paddr == REG_DELAY) begin
        nxt_st.dlyMs = pwdata[15:0];
      end else if (paddr == REG_RAMP) begin
        nxt_st.rampMs = pwdata[15:0];
      end else if (paddr == REG_PGDLY) begin
        nxt_st.pgDlyMs  = pwdata[15:0];                                        // [RULE13]
        nxt_st.pgDlySet = 1'b1;
      end else if (paddr == REG_PGWIN) begin
        nxt_st.pgLow  = pwdata[7:0];                                           // [RULE11]
        nxt_st.pgHigh = pwdata[15:8];
      end else if (paddr == REG_RATE) begin
        // out-of-range requests are held to the legal span [RULE18]
        nxt_st.fBus = 1'b1;
        if (pwdata[15:0] < 16'(RATE_MIN)) begin
          nxt_st.fReq = RATE_MIN;
        end else if (pwdata[15:0] > 16'(RATE_MAX)) begin
          nxt_st.fReq = RATE_MAX;
        end else begin
          nxt_st.fReq = pwdata[9:0];
        end
      end
    end

    // millisecond timebase, restarted while off so the first delay tick is whole
    nxt_st.msCnt = (msTick || st_ff.seq == SEQ_OFF) ? 17'h0 : st_ff.msCnt + 17'h1;

    // soft-start sequence
    case (st_ff.seq)
      SEQ_OFF: begin
        nxt_st.vTarget = 12'h0;
        if (turnOn && st_ff.strapDone) begin
          nxt_st.seq   = SEQ_DELAY;                                            // [RULE6]
          nxt_st.timer = (st_ff.dlyMs == 16'h0) ? INIT_MS : st_ff.dlyMs;       // [RULE7]
        end
      end
      SEQ_DELAY: begin
        if (!turnOn) begin
          nxt_st.seq = SEQ_OFF;
        end else if (msTick) begin
          nxt_st.timer = st_ff.timer - 16'h1;
          if (st_ff.timer <= 16'h1) begin
            if (st_ff.rampMs == 16'h0) begin
              nxt_st.vTarget = voutEff;                                        // [RULE8]
              nxt_st.seq     = SEQ_ON;
            end else begin
              nxt_st.seq      = SEQ_RAMP;                                      // [RULE6]
              nxt_st.timer    = st_ff.rampMs;
              nxt_st.rampStep = 12'((32'(voutEff) + 32'(st_ff.rampMs) - 32'd1) / 32'(st_ff.rampMs));
            end
          end
        end
      end
      SEQ_RAMP: begin
        // linear ramp in per-millisecond steps; last step lands on the target
        if (!turnOn) begin
          nxt_st.seq = SEQ_OFF;
        end else if (msTick) begin
          nxt_st.timer = st_ff.timer - 16'h1;
          if (st_ff.timer <= 16'h1 || 13'(st_ff.vTarget) + 13'(st_ff.rampStep) >= 13'(voutEff)) begin
            nxt_st.vTarget = voutEff;
            nxt_st.seq     = SEQ_ON;
          end else begin
            nxt_st.vTarget = st_ff.vTarget + st_ff.rampStep;
          end
        end
      end
      SEQ_ON: begin
        nxt_st.vTarget = voutEff;                 // later reprogramming applies directly
        if (!turnOn) begin
          nxt_st.seq = SEQ_OFF;
        end
      end
      default: begin
        nxt_st.seq = SEQ_OFF;
      end
    endcase

    // power-good qualification: delayed rise, immediate fall
    if (!pgCond) begin
      nxt_st.pgQual = 1'b0;                                                    // [RULE23]
      nxt_st.pgCnt  = 16'h0;
    end else if (!st_ff.pgQual) begin
      if (st_ff.pgCnt >= pgDlyEff) begin
        nxt_st.pgQual = 1'b1;                                                  // [RULE12]
      end else if (msTick) begin
        nxt_st.pgCnt = st_ff.pgCnt + 16'h1;
      end
    end
    nxt_st.pgOut = (pgCond && st_ff.pgQual) ^ st_ff.pgInv;                     // [RULE10] [RULE11]

    // external clock detection; source mode ignores the line it drives itself
    if (extEdge) begin
      nxt_st.lossCnt    = 8'h0;
      nxt_st.clkPresent = ~st_ff.syncSrc;
    end else if (st_ff.lossCnt >= 8'(SYNC_LOSS_CYC)) begin
      nxt_st.clkPresent = 1'b0;
    end else begin
      nxt_st.lossCnt = st_ff.lossCnt + 8'h1;
    end

    // 8 MHz enable from a fractional accumulator, then divide by N
    nxt_st.nDiv    = nCalc;
    nxt_st.swPulse = 1'b0;
    if (st_ff.acc + TICK_NUM >= TICK_DEN) begin
      nxt_st.acc = st_ff.acc + TICK_NUM - TICK_DEN;
    end else begin
      nxt_st.acc = st_ff.acc + TICK_NUM;
    end
    if (st_ff.clkPresent && !st_ff.syncSrc) begin
      // lock: each rising edge of the outside clock starts a switching period [RULE14]
      if (extEdge) begin
        nxt_st.divCnt  = 5'h0;
        nxt_st.swPulse = 1'b1;
      end
    end else if (st_ff.acc + TICK_NUM >= TICK_DEN) begin
      if (st_ff.divCnt >= st_ff.nDiv - 5'h1) begin
        nxt_st.divCnt  = 5'h0;
        nxt_st.swPulse = 1'b1;                                                 // [RULE19]
      end else begin
        nxt_st.divCnt = st_ff.divCnt + 5'h1;
      end
    end
    // as source, drive a near-square clock on the shared line
    nxt_st.syncOe  = st_ff.syncSrc;
    nxt_st.syncOut = st_ff.syncSrc && (st_ff.divCnt < (st_ff.nDiv >> 1));
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff          <= '0;
      st_ff.seq      <= SEQ_OFF;
      st_ff.pgLow    <= PG_LOW_DEF;
      st_ff.pgHigh   <= PG_HIGH_DEF;
      st_ff.fReq     <= RATE_MIN;
      st_ff.nDiv     <= 5'h14;
      st_ff.voutCmd  <= VOUT_MIN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign pgOut   = st_ff.pgOut;
  assign swPulse = st_ff.swPulse;
  assign syncOut = st_ff.syncOut;
  assign syncOe  = st_ff.syncOe;
  assign vTarget = st_ff.vTarget;
  assign smbAddr = st_ff.smbAddr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence delay_ends_s;
    st_ff.seq == SEQ_DELAY && turnOn && msTick && st_ff.timer <= 16'h1;
  endsequence
  sequence start_req_s;
    st_ff.seq == SEQ_OFF && turnOn && st_ff.strapDone;
  endsequence

  start_to_delay_a: assert property (start_req_s |=> st_ff.seq == SEQ_DELAY) // [RULE6]
    else $error("turn-on did not start the delay timer");
  init_delay_a: assert property (start_req_s and (st_ff.dlyMs == 16'h0) |=> st_ff.timer == INIT_MS) // [RULE7]
    else $error("zero delay did not load the initialisation time");
  zero_ramp_a: assert property (delay_ends_s and (st_ff.rampMs == 16'h0) |=> // [RULE8]
      st_ff.seq == SEQ_ON && st_ff.vTarget == $past(voutEff))
    else $error("zero ramp did not step to the final level");
  ramp_start_a: assert property (delay_ends_s and (st_ff.rampMs != 16'h0) |=> // [RULE6]
      st_ff.seq == SEQ_RAMP && st_ff.vTarget == 12'h0)
    else $error("ramp did not begin from zero after the delay");
  ceiling_clamp_a: assert property (st_ff.strapDone |-> st_ff.vTarget <= vMax) // [RULE3]
    else $error("target above the output voltage ceiling");
  vout_range_a: assert property (st_ff.strapDone |-> voutEff >= VOUT_MIN && voutEff <= VOUT_TOP) // [RULE5]
    else $error("commanded level outside 0.6 V to 3.6 V");
  pg_drop_fast_a: assert property (!pgCond |=> !st_ff.pgQual ##1 st_ff.pgOut == st_ff.pgInv) // [RULE23]
    else $error("power-good did not drop at once");
  pg_delay_a: assert property ($rose(st_ff.pgQual) |-> $past(st_ff.pgCnt) >= $past(pgDlyEff)) // [RULE12]
    else $error("power-good asserted before its delay");
  strap_hold_a: assert property (st_ff.strapDone |=> $stable(st_ff.fStrap) && $stable(st_ff.smbAddr)) // [RULE17]
    else $error("strap value changed after start-up");
  rate_quant_a: assert property (st_ff.strapDone |-> st_ff.nDiv >= 5'h8 && st_ff.nDiv <= 5'h14) // [RULE19]
    else $error("divisor outside the legal rate span");
  sync_lock_a: assert property (extEdge && st_ff.clkPresent && !st_ff.syncSrc |=> // [RULE14]
      st_ff.swPulse && st_ff.divCnt == 5'h0)
    else $error("switching period not locked to the outside clock edge");
endmodule

//--- test/sps_plant_model.sv
// partner model: output stage and shared switch-clock line seen by the sequencer
`timescale 1ns/10ps
module sps_plant_model import sps_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic [11:0] vTarget,
  input  wire logic [7:0]  pct,
  input  wire logic        extClkOn,
  output logic [11:0]      vMeas,
  output logic             extClk
);
  logic [6:0] phase = 7'h00;
  // output follows the target scaled by pct, one cycle late like a slow loop
  always @(posedge clk_sys) begin
    vMeas <= 12'((32'(vTarget) * 32'(pct)) / 100);
    phase <= (phase == 7'h7c) ? 7'h00 : phase + 7'h01;
    // a single source of 400 kHz on the shared line, held low when off
    extClk <= extClkOn && (phase < 7'h3e);
  end
endmodule

//--- test/sps_top_tb.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/10ps
module sps_top_tb import sps_pkg::*;;
  localparam int MSC = 20;
  logic        clk_sys, reset_n, psel, penable, pwrite, turnOnPin, faultActive, extClkOn;
  logic        pready, pslverr, err, syncOut, syncOe, pgOut, swPulse, extClk, syncLine;
  logic [7:0]  paddr, pct;
  logic [31:0] pwdata, prdata, rd, vFin;
  logic [4:0]  addrIdx, voltIdx;
  logic [3:0]  rateIdx;
  logic [11:0] vMeas, vTarget, vStrap, vMax;
  logic [6:0]  smbAddr;
  int          errTotal = 0, nTests = 0, seed = 98816, cyc = 0, i, f, hi;
  // line level: the design wins only while it drives
  assign syncLine = syncOe ? syncOut : extClk;
  sps_top #(.MS_CYCLES(MSC)) u_sps_top (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .addrStrapIdx(addrIdx), .voltStrapIdx(voltIdx),
    .rateStrapIdx(rateIdx), .turnOnPin(turnOnPin), .syncIn(syncLine), .syncOut(syncOut),
    .syncOe(syncOe), .vMeas(vMeas), .faultActive(faultActive), .pgOut(pgOut),
    .swPulse(swPulse), .vTarget(vTarget), .smbAddr(smbAddr));
  sps_plant_model u_sps_plant_model (.clk_sys(clk_sys), .vTarget(vTarget), .pct(pct),
    .extClkOn(extClkOn), .vMeas(vMeas), .extClk(extClk));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errTotal++;
      printVerdict();
    end
  end
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; the idle edge after it keeps psel from being driven twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] qrate(int fr);
    int n;
    n = (8000 + fr / 2) / fr;
    return 32'(8000 / n);
  endfunction
  function automatic logic [31:0] clampV(int c);
    int v;
    v = (c > int'(vMax)) ? int'(vMax) : c;
    return 32'((v < 600) ? 600 : v);
  endfunction
  // cycles from one switching pulse to the next; hi counts the cycles with the line driven high
  task automatic period();
    while (swPulse !== 1'b1) @(posedge clk_sys);
    i = 0;
    hi = 0;
    do begin @(posedge clk_sys); i++; hi += int'(syncOut); end while (swPulse !== 1'b1 && i < 300);
  endtask
  task automatic waitCyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    turnOnPin = 1'b0; faultActive = 1'b0; extClkOn = 1'b0; pct = 8'h64;
    addrIdx = 5'($unsigned($random(seed)) % 32);
    voltIdx = 5'($unsigned($random(seed)) % 29);
    rateIdx = 4'($unsigned($random(seed)) % 10);
    vStrap = VOLT_TAB[voltIdx];
    vMax = 12'((32'(vStrap) * 11) / 10);
    f = int'(RATE_TAB[rateIdx]);
    waitCyc(16);
    reset_n <= 1'b1;
    waitCyc(8);
    rateIdx <= rateIdx ^ 4'h1;
    chk("address", 32'(ADDR_BASE + 7'(addrIdx)), 32'(smbAddr));
    apb(1'b0, REG_VMAX, 0); chk("ceiling", 32'(vMax), rd);
    apb(1'b0, REG_VOUT, 0); chk("vout strap", 32'(vStrap), rd);
    apb(1'b0, REG_RATE, 0); chk("rate strap", qrate(f), rd);
    apb(1'b0, 8'h3c, 0); chk("unmapped", 32'h1, 32'(err));
    for (i = 0; i < 8; i++) begin
      f = (i == 0) ? 810 : (i == 1) ? 400 : (i == 2) ? 1000 : 400 + $unsigned($random(seed)) % 601;
      apb(1'b1, REG_RATE, 32'(f));
      apb(1'b0, REG_RATE, 0); chk("rate", qrate(f), rd);
    end
    for (i = 0; i < 6; i++) begin
      f = (i == 0) ? 3600 : (i == 1) ? 600 : 600 + $unsigned($random(seed)) % 3001;
      apb(1'b1, REG_VOUT, 32'(f));
      apb(1'b0, REG_VOUT, 0); chk("vout", clampV(f), rd);
    end
    vFin = clampV(f);
    // ramp kept two ticks long, turn-on through the bus with the pin low
    apb(1'b1, REG_DELAY, 3); apb(1'b1, REG_RAMP, 2); apb(1'b1, REG_CTRL, 1);
    apb(1'b0, REG_STATUS, 0); chk("in delay", 32'h1, rd & 32'h3);
    chk("no ramp yet", 0, 32'(vTarget));
    i = 0;
    do begin apb(1'b0, REG_STATUS, 0); i++; end while (rd[1:0] !== 2'h3 && i < 100);
    chk("ramp end", vFin, 32'(vTarget));
    chk("pg delayed", 0, 32'(pgOut));
    apb(1'b0, REG_PGDLY, 0);
    chk("pg delay dflt", 32'd2, rd);
    i = 0;
    while (pgOut !== 1'b1 && i < 200) begin @(posedge clk_sys); i++; end
    chk("pg up", 32'h1, 32'(pgOut));
    faultActive <= 1'b1; waitCyc(3); chk("pg fault", 0, 32'(pgOut));
    faultActive <= 1'b0; pct <= 8'h55; waitCyc(80); chk("pg window", 0, 32'(pgOut));
    apb(1'b1, REG_PGWIN, 32'h7850); waitCyc(80); chk("pg wide", 32'h1, 32'(pgOut));
    apb(1'b1, REG_CTRL, 3); waitCyc(4); chk("pg invert", 0, 32'(pgOut));
    pct <= 8'h64;
    apb(1'b1, REG_CTRL, 0); apb(1'b1, REG_DELAY, 0); apb(1'b1, REG_RAMP, 0);
    apb(1'b1, REG_PGDLY, 5); apb(1'b1, REG_CTRL, 1);
    i = 0;
    while (vTarget === 12'h000 && i < 200) begin @(posedge clk_sys); i++; end
    chk("init wait", 32'h1, 32'(i >= 2 * MSC - 4 && i <= 2 * MSC + 6));
    chk("step", vFin, 32'(vTarget));
    // own delay of 5 ms, although the ramp time is now zero
    i = 0;
    while (pgOut !== 1'b1 && i < 300) begin @(posedge clk_sys); i++; end
    chk("pg own delay", 32'h1, 32'(i >= 5 * MSC && i <= 5 * MSC + 6));
    apb(1'b0, REG_PGDLY, 0);
    chk("pg delay reg", 32'd5, rd);
    extClkOn <= 1'b1; waitCyc(600);
    apb(1'b0, REG_STATUS, 0); chk("ext clock", 32'h1, 32'(rd[5]));
    period();
    chk("locked period", 32'd125, 32'(i));
    // source mode at 500 kHz: 16 enables of 8 MHz per period, half of them with the line high
    apb(1'b1, REG_RATE, 32'd500);
    apb(1'b1, REG_CTRL, 32'h5);
    waitCyc(4);
    chk("sync drive", 32'h1, 32'(syncOe));
    period();
    chk("free period", 32'd100, 32'(i));
    chk("sync high", 32'd50, 32'(hi));
    apb(1'b0, REG_STATUS, 0);
    chk("own clock", 32'h0, 32'(rd[5]));
    printVerdict();
  end
endmodule
